// *** logic/rtc_serial_slave.sv ***
`timescale 1ns/1ps
module rtc_serial_slave
    import rtc_pkg::*;
#(
    parameter int XTAL_DIV = XTAL_HZ
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic crystal_in,
    output logic crystal_out,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [2:0] pointer
);
    typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_RACK} state_e;
    localparam int DIV_W = $clog2(XTAL_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(XTAL_DIV - 1);

    state_e state_r;
    state_e ret_r;
    logic [DIV_W-1:0] div_r;
    logic xtal_d_r, scl_d_r, sda_d_r;
    logic tick, xtal_rise, scl_rise, scl_fall, start_c, stop_c;
    logic [7:0] shift_r;
    logic [3:0] bit_r;
    logic ack_r, ack_phase_r, rnw_r;
    logic [2:0] ptr_r;
    logic frozen_r;
    logic [63:0] counts, user_r;
    logic wr_en;
    logic [7:0] rd_byte;
    logic [2:0] ptr_inc;
    logic byte_done;

    assign crystal_out = ~crystal_in;
    assign xtal_rise = crystal_in && !xtal_d_r;
    assign tick = xtal_rise && div_r == DIV_LAST;
    assign scl_rise = scl_in && !scl_d_r;
    assign scl_fall = !scl_in && scl_d_r;
    // Inputs sampled synchronously; 40 MHz oversamples a 400 kHz bus widely
    assign start_c = scl_in && scl_d_r && sda_d_r && !sda_in;
    assign stop_c = scl_in && scl_d_r && !sda_d_r && sda_in;
    assign ptr_inc = ptr_r + 3'h1;
    assign rd_byte = user_r[ptr_r*8 +: 8];
    assign byte_done = scl_fall && bit_r == 4'h8 && !ack_phase_r;
    assign wr_en = byte_done && state_r == ST_WDATA;
    assign pointer = ptr_r;

    bcd_calendar u_cal (
        .mclk(mclk),
        .rst(rst),
        .tick(tick),
        .wr_en(wr_en),
        .wr_loc(ptr_r),
        .wr_data(shift_r),
        .counts(counts)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_r <= '0;
            xtal_d_r <= 1'b0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            xtal_d_r <= crystal_in;
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
            if (xtal_rise) div_r <= (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
        end
    end

    // User copy follows counters except while a clock location is addressed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            user_r <= '0;
            frozen_r <= 1'b0;
        end else begin
            if (!frozen_r) user_r <= counts;
            if (stop_c || ptr_r == LOC_CAL) frozen_r <= 1'b0;
            else if (state_r inside {ST_WDATA, ST_RDATA, ST_RACK}) frozen_r <= 1'b1;
            if (wr_en) user_r[ptr_r*8 +: 8] <= shift_r;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            ret_r <= ST_IDLE;
            shift_r <= 8'h00;
            bit_r <= 4'h0;
            ack_phase_r <= 1'b0;
            ack_r <= 1'b0;
            rnw_r <= 1'b0;
            ptr_r <= LOC_SEC;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_c) begin
            state_r <= ST_ADDR;
            bit_r <= 4'h0;
            ack_phase_r <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            state_r <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (state_r != ST_IDLE) begin
            if (scl_rise && !ack_phase_r && state_r != ST_RDATA) begin
                shift_r <= {shift_r[6:0], sda_in};
                bit_r <= bit_r + 4'h1;
            end
            if (scl_rise && state_r == ST_RACK) begin
                ack_r <= sda_in;
            end
            if (scl_fall) begin
                if (ack_phase_r) begin
                    ack_phase_r <= 1'b0;
                    bit_r <= 4'h0;
                    sda_oe <= 1'b0;
                    state_r <= ret_r;
                    if (ret_r == ST_RDATA) begin
                        sda_oe <= !rd_byte[7];
                        shift_r <= {rd_byte[6:0], 1'b0};
                        bit_r <= 4'h1;
                    end
                end else if (state_r == ST_RDATA) begin
                    if (bit_r == 4'h8) begin
                        sda_oe <= 1'b0;
                        state_r <= ST_RACK;
                        ptr_r <= ptr_inc;
                    end else begin
                        sda_oe <= !shift_r[7];
                        shift_r <= {shift_r[6:0], 1'b0};
                        bit_r <= bit_r + 4'h1;
                    end
                end else if (state_r == ST_RACK) begin
                    if (ack_r) begin
                        state_r <= ST_IDLE;
                    end else begin
                        state_r <= ST_RDATA;
                        sda_oe <= !rd_byte[7];
                        shift_r <= {rd_byte[6:0], 1'b0};
                        bit_r <= 4'h1;
                    end
                end else if (bit_r == 4'h8) begin
                    ack_phase_r <= 1'b1;
                    sda_oe <= 1'b1;
                    case (state_r)
                        ST_ADDR: begin
                            if (shift_r[7:1] == SLAVE_ADDR) begin
                                rnw_r <= shift_r[0];
                                ret_r <= shift_r[0] ? ST_RDATA : ST_PTR;
                            end else begin
                                ack_phase_r <= 1'b0;
                                sda_oe <= 1'b0;
                                state_r <= ST_IDLE;
                            end
                        end
                        ST_PTR: begin
                            ptr_r <= shift_r[2:0];
                            ret_r <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            ptr_r <= ptr_inc;
                            ret_r <= ST_WDATA;
                        end
                        default: begin
                            ret_r <= ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end
endmodule

// *** common/rtc_pkg.sv ***
package rtc_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h68;
    localparam int NUM_LOCS = 8;
    localparam logic [2:0] LOC_SEC = 3'h0;
    localparam logic [2:0] LOC_MIN = 3'h1;
    localparam logic [2:0] LOC_HOUR = 3'h2;
    localparam logic [2:0] LOC_DAY = 3'h3;
    localparam logic [2:0] LOC_DATE = 3'h4;
    localparam logic [2:0] LOC_MONTH = 3'h5;
    localparam logic [2:0] LOC_YEAR = 3'h6;
    localparam logic [2:0] LOC_CAL = 3'h7;
    localparam int HOUR_CENT_BIT = 6;
    localparam int XTAL_HZ = 32768;
    localparam logic [7:0] RST_SEC = 8'h00;
    localparam logic [7:0] RST_MIN = 8'h00;
    localparam logic [7:0] RST_HOUR = 8'h00;
    localparam logic [7:0] RST_DAY = 8'h01;
    localparam logic [7:0] RST_DATE = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] RST_CAL = 8'h00;
    localparam int BUS_HZ_MAX = 400000;
    localparam int CLK_HZ = 40000000;
endpackage

// *** logic/bcd_calendar.sv ***
`timescale 1ns/1ps
module bcd_calendar
    import rtc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input wire logic wr_en,
    input wire logic [2:0] wr_loc,
    input wire logic [7:0] wr_data,
    output logic [63:0] counts
);
    logic [7:0] loc_r [NUM_LOCS];
    logic [7:0] sec, mn, hr, dy, dt, mo, yr;
    logic cent;
    logic [7:0] last_day;
    logic leap;
    logic sec_end, min_end, hr_end, dt_end, mo_end, yr_end;
    logic [7:0] hr_inc;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    assign sec = loc_r[LOC_SEC];
    assign mn = loc_r[LOC_MIN];
    assign hr = {2'h0, loc_r[LOC_HOUR][5:0]};
    assign cent = loc_r[LOC_HOUR][HOUR_CENT_BIT];
    assign dy = loc_r[LOC_DAY];
    assign dt = loc_r[LOC_DATE];
    assign mo = loc_r[LOC_MONTH];
    assign yr = loc_r[LOC_YEAR];
    // BCD year divisible by four; 2000 is leap, valid through 2099
    assign leap = (yr[4] ? (yr[1:0] == 2'h2) : (yr[1:0] == 2'h0));
    assign last_day = (mo == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                      (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) ? 8'h30 :
                      8'h31;
    assign sec_end = tick && sec == 8'h59;
    assign min_end = sec_end && mn == 8'h59;
    assign hr_end = min_end && hr == 8'h23;
    assign dt_end = hr_end && dt == last_day;
    assign mo_end = dt_end && mo == 8'h12;
    assign yr_end = mo_end && yr == 8'h99;
    assign hr_inc = bcd_inc(hr);

    genvar g;
    generate
        for (g = 0; g < NUM_LOCS; g++) begin : g_loc
            assign counts[g*8 +: 8] = loc_r[g];
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            loc_r[LOC_SEC] <= RST_SEC;
            loc_r[LOC_MIN] <= RST_MIN;
            loc_r[LOC_HOUR] <= RST_HOUR;
            loc_r[LOC_DAY] <= RST_DAY;
            loc_r[LOC_DATE] <= RST_DATE;
            loc_r[LOC_MONTH] <= RST_MONTH;
            loc_r[LOC_YEAR] <= RST_YEAR;
            loc_r[LOC_CAL] <= RST_CAL;
        end else if (wr_en) begin
            loc_r[wr_loc] <= wr_data;
        end else if (tick) begin
            loc_r[LOC_SEC] <= sec_end ? 8'h00 : bcd_inc(sec);
            if (sec_end) loc_r[LOC_MIN] <= (mn == 8'h59) ? 8'h00 : bcd_inc(mn);
            // Century flag flips only when the year wraps from 99 to 00
            if (min_end) loc_r[LOC_HOUR] <= {loc_r[LOC_HOUR][7], cent ^ yr_end,
                hr_end ? 6'h00 : hr_inc[5:0]};
            if (hr_end) loc_r[LOC_DAY] <= (dy == 8'h07) ? 8'h01 : bcd_inc(dy);
            if (hr_end) loc_r[LOC_DATE] <= dt_end ? 8'h01 : bcd_inc(dt);
            if (dt_end) loc_r[LOC_MONTH] <= mo_end ? 8'h01 : bcd_inc(mo);
            if (mo_end) loc_r[LOC_YEAR] <= yr_end ? 8'h00 : bcd_inc(yr);
        end
    end
endmodule

// *** test/rtc_checker_properties.sv ***
`timescale 1ns/1ps
module rtc_checker #(
    parameter int XTAL_DIV = 32768
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic crystal_in,
    input wire logic crystal_out,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [2:0] pointer
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_fb; crystal_out == !crystal_in; endproperty
    a_fb: assert property (p_fb) else $error("crystal feedback wrong");
    property p_low; sda_out == 1'b0; endproperty
    a_low: assert property (p_low) else $error("data pin driven high");
    property p_rise; $rose(sda_oe) |-> !scl_in; endproperty
    a_rise: assert property (p_rise) else $error("data drive starts in clock high");
    property p_high; (scl_in && $past(scl_in)) |-> $stable(sda_oe); endproperty
    a_high: assert property (p_high) else $error("data moved in clock high");
    property p_hold; $rose(sda_oe) |-> sda_oe [*8]; endproperty
    a_hold: assert property (p_hold) else $error("data drive too short");
    property p_stop; ($rose(sda_in) && scl_in) |=> !sda_oe [*4]; endproperty
    a_stop: assert property (p_stop) else $error("drive after stop");
    property p_ptr0; $fell(rst) |-> (pointer == 3'h0 && !sda_oe); endproperty
    a_ptr0: assert property (p_ptr0) else $error("pointer not at seconds");
    property p_bound; sda_oe |-> ##[1:1000] !sda_oe; endproperty
    a_bound: assert property (p_bound) else $error("data drive stuck");
    c_ack: cover property ($rose(sda_oe));
    c_wrap: cover property (pointer == 3'h7 ##1 pointer == 3'h0);
    c_stop: cover property ($rose(sda_in) && scl_in);
endmodule
bind rtc_serial_slave rtc_checker #(.XTAL_DIV(XTAL_DIV)) u_rtc_checker(.mclk(mclk), .rst(rst),
    .crystal_in(crystal_in), .crystal_out(crystal_out), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .pointer(pointer));

// *** test/i2c_master_model.sv ***
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic mclk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_m
);
    localparam int Q = 25;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        wt(Q);
        scl <= 1'b1;
        wt(Q);
        r = sda_in;
        wt(Q);
        scl <= 1'b0;
        wt(Q);
    endtask
    task automatic start();
        sda_m <= 1'b1;
        wt(Q);
        scl <= 1'b1;
        wt(Q);
        sda_m <= 1'b0;
        wt(Q);
        scl <= 1'b0;
        wt(Q);
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        wt(Q);
        scl <= 1'b1;
        wt(Q);
        sda_m <= 1'b1;
        wt(2 * Q);
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic byte_in(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule

// *** test/bcd_calendar_rtc_serial_slave_tb_top.sv ***
`timescale 1ns/1ps
module bcd_calendar_rtc_serial_slave_tb_top;
    import rtc_pkg::*;
    logic mclk, rst, crystal_in, crystal_out, scl, sda_m, sda_out, sda_oe, ack;
    logic [2:0] pointer;
    logic [7:0] rd[8], wv[8], ev[8];
    logic [7:0] t_dt[3] = '{8'h28, 8'h28, 8'h31}, t_mo[3] = '{8'h02, 8'h02, 8'h12};
    logic [7:0] t_yr[3] = '{8'h23, 8'h24, 8'h99}, t_hr[3] = '{8'h00, 8'h00, 8'h40};
    logic [7:0] t_edt[3] = '{8'h01, 8'h29, 8'h01}, t_emo[3] = '{8'h03, 8'h02, 8'h01};
    logic [7:0] t_eyr[3] = '{8'h23, 8'h24, 8'h00};
    wire sda_in;
    int n_errors, n_checks, cyc, seed;
    int unsigned v;
    assign sda_in = sda_m & ~sda_oe;
    rtc_serial_slave #(.XTAL_DIV(4)) u_rtc_serial_slave(.mclk(mclk), .rst(rst),
        .crystal_in(crystal_in), .crystal_out(crystal_out), .scl_in(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .pointer(pointer));
    i2c_master_model u_i2c_master_model(.mclk(mclk), .sda_in(sda_in), .scl(scl), .sda_m(sda_m));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 95000) begin
            n_errors++;
            close_out();
        end
    end
    function automatic logic [7:0] bcd(int x);
        return {4'(x / 10), 4'(x % 10)};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic put(logic [7:0] d);
        u_i2c_master_model.byte_out(d, ack);
        chk("ack", {7'h0, ack}, 8'h00);
    endtask
    task automatic xfer(bit wr, bit load);
        u_i2c_master_model.start();
        if (wr || load) begin
            put({SLAVE_ADDR, 1'b0});
            put(8'h00);
        end
        if (wr) begin
            foreach (wv[i]) put(wv[i]);
        end else begin
            if (load) u_i2c_master_model.start();
            put({SLAVE_ADDR, 1'b1});
            foreach (rd[i]) u_i2c_master_model.byte_in(i == 7, rd[i]);
        end
        u_i2c_master_model.stop();
    endtask
    task automatic tick();
        repeat (4) begin
            crystal_in <= 1'b1;
            u_i2c_master_model.wt(4);
            crystal_in <= 1'b0;
            u_i2c_master_model.wt(4);
        end
    endtask
    initial begin
        seed = 92268;
        rst = 1'b1;
        crystal_in = 1'b0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        u_i2c_master_model.wt(4);
        xfer(0, 0);
        ev = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
        foreach (rd[i]) chk("reset byte", rd[i], ev[i]);
        chk("pointer", {5'h0, pointer}, 8'h00);
        $display("test reset read done");
        for (int k = 0; k < 4; k++) begin
            v = $unsigned($random(seed));
            if (k < 3) begin
                wv = '{8'h59, 8'h59, 8'h23, 8'h07, t_dt[k], t_mo[k], t_yr[k], bcd(v % 100)};
                ev = '{8'h00, 8'h00, t_hr[k], 8'h01, t_edt[k], t_emo[k], t_eyr[k], wv[7]};
            end else begin
                wv = '{bcd(v % 59), bcd(v % 60), bcd(v % 24), bcd(v % 7 + 1),
                    bcd(v % 28 + 1), bcd(v % 12 + 1), bcd(v % 100), bcd(v % 97)};
                ev = wv;
                ev[0] = bcd(v % 59 + 1);
            end
            xfer(1, 1);
            chk("pointer wrap", {5'h0, pointer}, 8'h00);
            if (k == 3) begin
                // Tick while the pointer sits on seconds: the user copy must hold
                u_i2c_master_model.start();
                put({SLAVE_ADDR, 1'b0});
                put(8'h00);
                tick();
                u_i2c_master_model.start();
                put({SLAVE_ADDR, 1'b1});
                u_i2c_master_model.byte_in(1'b1, rd[0]);
                u_i2c_master_model.stop();
                chk("frozen second", rd[0], wv[0]);
            end else begin
                tick();
            end
            xfer(0, 1);
            foreach (rd[i]) chk("calendar byte", rd[i], ev[i]);
            $display("test calendar case %0d done", k);
        end
        v = $unsigned($random(seed)) % 127;
        if (v >= 32'h68) v++;
        u_i2c_master_model.start();
        u_i2c_master_model.byte_out({7'(v), 1'b0}, ack);
        chk("foreign ack", {7'h0, ack}, 8'h01);
        u_i2c_master_model.stop();
        $display("test foreign address done");
        close_out();
    end
endmodule
